// [shared/adc_sel_pkg.sv]
// Constants for the select-mode converter control block
package adc_sel_pkg;

  // Register offsets on the plain register port
  localparam logic [2:0] OFF_MODE    = 3'h0;
  localparam logic [2:0] OFF_CHANNEL = 3'h1;
  localparam logic [2:0] OFF_WIDE    = 3'h2;
  localparam logic [2:0] OFF_HIGH    = 3'h3;
  localparam logic [2:0] OFF_FLAG    = 3'h4;

  // Mode register fields
  localparam int MODE_RUN_BIT    = 7;
  localparam int MODE_ENABLE_BIT = 0;
  localparam int MODE_TIME_LSB   = 3;
  localparam int MODE_TIME_W     = 3;

  // Channel register field and flag register field
  localparam int CHAN_W        = 2;
  localparam int FLAG_BIT      = 0;

  // Result layout
  localparam int RES_W        = 10;
  localparam int HIGH_LSB     = 2;
  localparam int DATA_W       = 16;

  // Reset values
  localparam logic [7:0]        MODE_RESET = 8'h00;
  localparam logic [CHAN_W-1:0] CHAN_RESET = 2'h0;

  // Cycles spent on each result bit of the search, and on the whole search
  localparam logic [9:0] BIT_CYCLES   = 10'h002;
  localparam logic [9:0] APPROX_TOTAL = 10'h014;

  // Whole conversion time in clock cycles, sampling included, per time code
  function automatic logic [9:0] conv_cycles(input logic [2:0] code);
    case (code)
      3'h0:    conv_cycles = 10'h028;
      3'h1:    conv_cycles = 10'h03C;
      3'h2:    conv_cycles = 10'h050;
      3'h3:    conv_cycles = 10'h078;
      3'h4:    conv_cycles = 10'h0A0;
      3'h5:    conv_cycles = 10'h0F0;
      3'h6:    conv_cycles = 10'h140;
      default: conv_cycles = 10'h1E0;
    endcase
  endfunction : conv_cycles

  typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_APPROX} conv_state_t;

endpackage : adc_sel_pkg

// [rtl/adc_select_mode_control.sv]
// Select-mode successive-approximation converter control
//
// Implementation choices: strobed register access and the register addresses.
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - Only select mode: converts one of four inputs chosen by channel bits 1:0.
// - Writing 1 to run bit 7 starts converting the selected input.
// - Each conversion end without a colliding mode or channel write loads both result registers and pulses the end interrupt.
// - Next conversion starts at once after each one while run stays set.
// - Any mode or channel write leaving run set during conversion restarts it from the beginning.
// - Writing run 0 stops conversion immediately; that result is undefined.
// - Mode holds enable at bit 0, time code at bits 5:3, run at 7.
// - After a channel write the next end comes one full conversion time later.
// - Result read colliding with a result load is served first, load follows.
// - Mode or channel write colliding with a load wins; no store, no interrupt.
// - Channel rewrite does not clear the conversion end flag.
// - Run 0 with enable 1 waits with only the comparator powered.
// - Conversion time counts from sampling start to result ready.
// - Search sets bits 9 to 0, keeping each where input is at least tap.
// - Wide result holds 10 bits right-aligned, upper six read 0, no reset.
// - High byte result presents the upper eight result bits.
module adc_select_mode_control (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 reset,
  // Register port
  input  wire logic [2:0]           reg_addr,
  input  wire logic [15:0]          reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic      [15:0]          reg_rdata,
  // Analog front end
  input  wire logic                 comp_ge,
  output logic      [1:0]           channel_mux,
  output logic                      sample_hold_on,
  output logic      [9:0]           tap_code,
  output logic                      comparator_power,
  // Interrupt request
  output logic                      conv_end_irq
);

  ////////////////////////////////////////////////////////////////////////////////
  // Register state
  logic [7:0]                       conv_mode_reg,        conv_mode_next;
  logic [1:0]                       channel_select_reg,   channel_select_next;
  logic [9:0]                       result_wide_reg,      result_wide_next;
  logic [7:0]                       result_high_byte_reg, result_high_byte_next;
  logic                             conv_end_flag_reg,    conv_end_flag_next;
  logic [15:0]                      rdata_reg,            rdata_next;
  logic                             irq_reg,              irq_next;

  // Conversion state
  adc_sel_pkg::conv_state_t         state_reg,            state_next;
  logic [9:0]                       cnt_reg,              cnt_next;
  logic [3:0]                       bit_idx_reg,          bit_idx_next;
  logic [9:0]                       approx_shift_reg,     approx_shift_next;
  logic [9:0]                       tap_reg,              tap_next;
  logic [1:0]                       mux_reg,              mux_next;
  logic                             sh_reg,               sh_next;
  logic                             cpow_reg,             cpow_next;

  // Decoded events
  logic                             wr_mode;
  logic                             wr_chan;
  logic                             ctl_wr;
  logic                             flag_clr;
  logic                             step_end;
  logic                             done_evt;
  logic [9:0]                       sar_final;
  logic [9:0]                       sample_len;
  logic [2:0]                       time_code;
  logic                             run_new;

  ////////////////////////////////////////////////////////////////////////////////
  // Decode
  always_comb begin
    wr_mode    = reg_wr && (reg_addr == adc_sel_pkg::OFF_MODE);
    wr_chan    = reg_wr && (reg_addr == adc_sel_pkg::OFF_CHANNEL);
    ctl_wr     = wr_mode || wr_chan;
    flag_clr   = reg_wr && (reg_addr == adc_sel_pkg::OFF_FLAG)
                 && reg_wdata[adc_sel_pkg::FLAG_BIT];
    time_code  = conv_mode_reg[adc_sel_pkg::MODE_TIME_LSB +: adc_sel_pkg::MODE_TIME_W];
    sample_len = adc_sel_pkg::conv_cycles(time_code) - adc_sel_pkg::APPROX_TOTAL;
    step_end   = (cnt_reg == adc_sel_pkg::BIT_CYCLES - 10'h001);
    done_evt   = (state_reg == adc_sel_pkg::ST_APPROX) && step_end && (bit_idx_reg == 4'h0);
    sar_final  = comp_ge ? tap_reg : approx_shift_reg;
    run_new    = wr_mode ? reg_wdata[adc_sel_pkg::MODE_RUN_BIT]
                         : conv_mode_reg[adc_sel_pkg::MODE_RUN_BIT];
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registers and read port
  always_comb begin
    conv_mode_next        = conv_mode_reg;
    channel_select_next   = channel_select_reg;
    result_wide_next      = result_wide_reg;
    result_high_byte_next = result_high_byte_reg;
    conv_end_flag_next    = conv_end_flag_reg;
    irq_next              = 1'b0;
    rdata_next            = 16'h0000;
    if (wr_mode) begin
      conv_mode_next = reg_wdata[7:0];
    end
    if (wr_chan) begin
      channel_select_next = reg_wdata[adc_sel_pkg::CHAN_W-1:0];
    end
    // Load wins only without a control write; reads sample the old value
    if (done_evt && !ctl_wr) begin
      result_wide_next      = sar_final;
      result_high_byte_next = sar_final[adc_sel_pkg::RES_W-1:adc_sel_pkg::HIGH_LSB];
      irq_next              = 1'b1;
    end
    // Set beats clear; channel writes leave the flag alone
    if (flag_clr) begin
      conv_end_flag_next = 1'b0;
    end
    if (done_evt && !ctl_wr) begin
      conv_end_flag_next = 1'b1;
    end
    if (reg_rd) begin
      case (reg_addr)
        adc_sel_pkg::OFF_MODE:    rdata_next = {8'h00, conv_mode_reg};
        adc_sel_pkg::OFF_CHANNEL: rdata_next = {14'h0000, channel_select_reg};
        adc_sel_pkg::OFF_WIDE:    rdata_next = {6'h00, result_wide_reg};
        adc_sel_pkg::OFF_HIGH:    rdata_next = {8'h00, result_high_byte_reg};
        adc_sel_pkg::OFF_FLAG:    rdata_next = {15'h0000, conv_end_flag_reg};
        default:                  rdata_next = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      conv_mode_reg      <= adc_sel_pkg::MODE_RESET;
      channel_select_reg <= adc_sel_pkg::CHAN_RESET;
      conv_end_flag_reg  <= 1'b0;
      rdata_reg          <= 16'h0000;
      irq_reg            <= 1'b0;
    end else begin
      conv_mode_reg      <= conv_mode_next;
      channel_select_reg <= channel_select_next;
      conv_end_flag_reg  <= conv_end_flag_next;
      rdata_reg          <= rdata_next;
      irq_reg            <= irq_next;
    end
  end

  // Result registers are undefined after reset
  always_ff @(posedge clk) begin
    result_wide_reg      <= result_wide_next;
    result_high_byte_reg <= result_high_byte_next;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Conversion sequencer
  always_comb begin
    state_next        = state_reg;
    cnt_next          = cnt_reg + 10'h001;
    bit_idx_next      = bit_idx_reg;
    approx_shift_next = approx_shift_reg;
    tap_next          = tap_reg;
    mux_next          = wr_chan ? reg_wdata[1:0] : channel_select_reg;
    cpow_next         = wr_mode ? reg_wdata[adc_sel_pkg::MODE_ENABLE_BIT]
                                : conv_mode_reg[adc_sel_pkg::MODE_ENABLE_BIT];
    case (state_reg)
      adc_sel_pkg::ST_IDLE: begin
        cnt_next = 10'h000;
      end
      adc_sel_pkg::ST_SAMPLE: begin
        if (cnt_reg >= sample_len - 10'h001) begin
          state_next        = adc_sel_pkg::ST_APPROX;
          cnt_next          = 10'h000;
          bit_idx_next      = 4'h9;
          approx_shift_next = 10'h000;
          tap_next          = 10'h200;
        end
      end
      adc_sel_pkg::ST_APPROX: begin
        if (step_end) begin
          cnt_next          = 10'h000;
          approx_shift_next = sar_final;
          if (bit_idx_reg == 4'h0) begin
            state_next = adc_sel_pkg::ST_SAMPLE;
          end else begin
            bit_idx_next = bit_idx_reg - 4'h1;
            tap_next     = sar_final | (10'h001 << (bit_idx_reg - 4'h1));
          end
        end
      end
      default: begin
        state_next = adc_sel_pkg::ST_IDLE;
        cnt_next   = 10'h000;
      end
    endcase
    // Run from idle, restart on control write, stop on run cleared
    if (state_reg == adc_sel_pkg::ST_IDLE || ctl_wr) begin
      if (run_new) begin
        state_next = adc_sel_pkg::ST_SAMPLE;
        cnt_next   = 10'h000;
      end else begin
        state_next = adc_sel_pkg::ST_IDLE;
        cnt_next   = 10'h000;
      end
    end
    sh_next = (state_next == adc_sel_pkg::ST_SAMPLE);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg        <= adc_sel_pkg::ST_IDLE;
      cnt_reg          <= 10'h000;
      bit_idx_reg      <= 4'h0;
      approx_shift_reg <= 10'h000;
      tap_reg          <= 10'h000;
      mux_reg          <= adc_sel_pkg::CHAN_RESET;
      sh_reg           <= 1'b0;
      cpow_reg         <= 1'b0;
    end else begin
      state_reg        <= state_next;
      cnt_reg          <= cnt_next;
      bit_idx_reg      <= bit_idx_next;
      approx_shift_reg <= approx_shift_next;
      tap_reg          <= tap_next;
      mux_reg          <= mux_next;
      sh_reg           <= sh_next;
      cpow_reg         <= cpow_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs
  always_comb begin
    reg_rdata        = rdata_reg;
    channel_mux      = mux_reg;
    sample_hold_on   = sh_reg;
    tap_code         = tap_reg;
    comparator_power = cpow_reg;
    conv_end_irq     = irq_reg;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  a_run_starts: assert property (@(posedge clk) disable iff (reset)
    (wr_mode && reg_wdata[7]) |=> (state_reg == adc_sel_pkg::ST_SAMPLE) && (cnt_reg == 10'h000))
    else $error("run write did not start sampling");

  a_restart_on_write: assert property (@(posedge clk) disable iff (reset)
    (wr_chan && run_new) |=> (state_reg == adc_sel_pkg::ST_SAMPLE) && sample_hold_on)
    else $error("channel write did not restart conversion");

  a_stop_now: assert property (@(posedge clk) disable iff (reset)
    (wr_mode && !reg_wdata[7]) |=> (state_reg == adc_sel_pkg::ST_IDLE) && !sample_hold_on)
    else $error("run clear did not stop conversion");

  a_store_result: assert property (@(posedge clk) disable iff (reset)
    (done_evt && !ctl_wr) |=> conv_end_irq && conv_end_flag_reg
      && (result_wide_reg == $past(sar_final)))
    else $error("conversion end did not load result");

  a_collision_drop: assert property (@(posedge clk) disable iff (reset)
    (done_evt && ctl_wr) |=> !conv_end_irq && $stable(result_wide_reg))
    else $error("control write collision still stored result");

  a_read_first: assert property (@(posedge clk) disable iff (reset)
    (done_evt && reg_rd && reg_addr == adc_sel_pkg::OFF_WIDE)
      |=> (reg_rdata[9:0] == $past(result_wide_reg)) && conv_end_irq)
    else $error("colliding read did not see old result");

  a_wide_upper_zero: assert property (@(posedge clk) disable iff (reset)
    (reg_rd && reg_addr == adc_sel_pkg::OFF_WIDE) |=> (reg_rdata[15:10] == 6'h00))
    else $error("wide result upper bits not zero");

  a_high_byte: assert property (@(posedge clk) disable iff (reset)
    conv_end_irq |-> (result_high_byte_reg == result_wide_reg[9:2]))
    else $error("high byte does not match wide result");

  a_flag_sticky: assert property (@(posedge clk) disable iff (reset)
    (conv_end_flag_reg && wr_chan) |=> conv_end_flag_reg)
    else $error("channel write cleared end flag");

  a_rerun_next: assert property (@(posedge clk) disable iff (reset)
    (done_evt && !ctl_wr && conv_mode_reg[7]) |=> (state_reg == adc_sel_pkg::ST_SAMPLE))
    else $error("next conversion did not start at once");

  a_sar_msb: assert property (@(posedge clk) disable iff (reset)
    (state_reg == adc_sel_pkg::ST_SAMPLE && state_next == adc_sel_pkg::ST_APPROX && !ctl_wr)
      |=> (tap_code == 10'h200) && (bit_idx_reg == 4'h9))
    else $error("search did not begin at bit 9");

  a_wait_power: assert property (@(posedge clk) disable iff (reset)
    (state_reg == adc_sel_pkg::ST_IDLE && !ctl_wr) |=> (comparator_power == conv_mode_reg[0])
      && !sample_hold_on)
    else $error("waiting state power wrong");

endmodule : adc_select_mode_control

// [tb/tb_top.sv]
// Self-checking bench for the select-mode converter control block
`timescale 1ns/100ps
module tb_top;
  ////////////////////////////////////////////////////////////////////////////
  // Ports, analog levels and counters
  logic        clk       = 1'b0;
  logic        reset     = 1'b1;
  logic [2:0]  reg_addr  = 3'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic [15:0] reg_rdata;
  logic        comp_ge;
  logic [1:0]  channel_mux;
  logic        sample_hold_on;
  logic [9:0]  tap_code;
  logic        comparator_power;
  logic        conv_end_irq;
  logic [9:0]  ain [4]      = '{10'h155, 10'h2AA, 10'h3FF, 10'h000};
  int          conv_len [8] = '{40, 60, 80, 120, 160, 240, 320, 480};
  int          n_errors     = 0;
  int          total_checks = 0;
  int          cyc          = 0;
  int          t_wr         = 0;
  int          lat;
  logic        seen;
  logic [15:0] val;

  always #12.5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  // Comparator model: selected input level against the trial tap
  assign comp_ge = (ain[channel_mux] >= tap_code);

  adc_select_mode_control u_dut (
    .clk              (clk),
    .reset            (reset),
    .reg_addr         (reg_addr),
    .reg_wdata        (reg_wdata),
    .reg_wr           (reg_wr),
    .reg_rd           (reg_rd),
    .reg_rdata        (reg_rdata),
    .comp_ge          (comp_ge),
    .channel_mux      (channel_mux),
    .sample_hold_on   (sample_hold_on),
    .tap_code         (tap_code),
    .comparator_power (comparator_power),
    .conv_end_irq     (conv_end_irq)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Tasks
  task automatic check(input string name, input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
    t_wr = cyc - 1;
  endtask : wr

  task automatic rd(input logic [2:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd

  task automatic wait_irq(output int n);
    n = -1;
    for (int i = 0; i < 1000 && n < 0; i++) begin
      @(posedge clk);
      #1;
      if (conv_end_irq === 1'b1) n = cyc - t_wr;
    end
  endtask : wait_irq

  task automatic give_verdict;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : give_verdict

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog
  initial begin
    #500000;
    n_errors++;
    give_verdict();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Tests
  initial begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    #1;
    check("irq idle", {15'h0, conv_end_irq}, 16'h0000);
    check("power reset", {15'h0, comparator_power}, 16'h0000);
    rd(adc_sel_pkg::OFF_MODE, val);
    check("mode reset", val, 16'h0000);
    rd(3'h5, val);
    check("unmapped", val, 16'h0000);
    @(posedge clk);
    #1;
    check("rdata idle", reg_rdata, 16'h0000);
    wr(adc_sel_pkg::OFF_MODE, 16'h0001);
    @(posedge clk);
    #1;
    check("power on", {15'h0, comparator_power}, 16'h0001);
    wr(adc_sel_pkg::OFF_CHANNEL, 16'h0002);
    rd(adc_sel_pkg::OFF_CHANNEL, val);
    check("channel", val, 16'h0002);
    repeat (40) @(posedge clk);
    wr(adc_sel_pkg::OFF_MODE, 16'h0081);
    @(posedge clk);
    #1;
    check("sampling", {15'h0, sample_hold_on}, 16'h0001);
    wait_irq(lat);
    check("first end", 16'(lat), 16'(41));
    t_wr = cyc;
    check("mux", {14'h0, channel_mux}, 16'h0002);
    rd(adc_sel_pkg::OFF_WIDE, val);
    check("wide", val, 16'h03FF);
    rd(adc_sel_pkg::OFF_HIGH, val);
    check("high", val, 16'h00FF);
    rd(adc_sel_pkg::OFF_FLAG, val);
    check("flag set", val, 16'h0001);
    wait_irq(lat);
    check("repeat", 16'(lat), 16'(40));
    for (int c = 0; c < 8; c++) begin
      wr(adc_sel_pkg::OFF_MODE, {8'h00, 2'b10, 3'(c), 3'b001});
      wait_irq(lat);
      check("time code", 16'(lat), 16'(conv_len[c] + 1));
    end
    wr(adc_sel_pkg::OFF_MODE, 16'h0081);
    wait_irq(lat);
    wr(adc_sel_pkg::OFF_CHANNEL, 16'h0001);
    rd(adc_sel_pkg::OFF_FLAG, val);
    check("flag kept", val, 16'h0001);
    wait_irq(lat);
    check("chan restart", 16'(lat), 16'(41));
    rd(adc_sel_pkg::OFF_WIDE, val);
    check("wide ch1", val, 16'h02AA);
    wr(adc_sel_pkg::OFF_WIDE, 16'h0000);
    rd(adc_sel_pkg::OFF_WIDE, val);
    check("wide ro", val, 16'h02AA);
    wr(adc_sel_pkg::OFF_FLAG, 16'h0001);
    wr(adc_sel_pkg::OFF_CHANNEL, 16'h0000);
    repeat (38) @(posedge clk);
    rd(adc_sel_pkg::OFF_WIDE, val);
    check("read first", val, 16'h02AA);
    rd(adc_sel_pkg::OFF_WIDE, val);
    check("load after", val, 16'h0155);
    wr(adc_sel_pkg::OFF_FLAG, 16'h0001);
    wr(adc_sel_pkg::OFF_CHANNEL, 16'h0003);
    repeat (38) @(posedge clk);
    wr(adc_sel_pkg::OFF_CHANNEL, 16'h0002);
    check("no irq", {15'h0, conv_end_irq}, 16'h0000);
    rd(adc_sel_pkg::OFF_WIDE, val);
    check("no store", val, 16'h0155);
    rd(adc_sel_pkg::OFF_FLAG, val);
    check("no flag", val, 16'h0000);
    wait_irq(lat);
    check("after clash", 16'(lat), 16'(41));
    rd(adc_sel_pkg::OFF_WIDE, val);
    check("wide ch2", val, 16'h03FF);
    wr(adc_sel_pkg::OFF_MODE, 16'h0001);
    seen = 1'b0;
    repeat (60) begin
      @(posedge clk);
      #1;
      if (conv_end_irq !== 1'b0) seen = 1'b1;
    end
    check("stopped", {15'h0, seen}, 16'h0000);
    check("wait power", {15'h0, comparator_power}, 16'h0001);
    check("no sample", {15'h0, sample_hold_on}, 16'h0000);
    wr(adc_sel_pkg::OFF_FLAG, 16'h0001);
    rd(adc_sel_pkg::OFF_FLAG, val);
    check("flag clear", val, 16'h0000);
    wr(adc_sel_pkg::OFF_MODE, 16'h0000);
    @(posedge clk);
    #1;
    check("power off", {15'h0, comparator_power}, 16'h0000);
    give_verdict();
  end
endmodule : tb_top
